// ---- hdl/bacr_top.sv ----
// Purpose: bus area control register with pin-sampled start flags
// Assumes: i_por is power-on reset; i_rst is manual reset only
// Notes: register survives manual reset and standby
// Functional notes
// RULE_01 - 32-bit register, zero on power-on only
// RULE_02 - software initialises before using other areas
// RULE_03 - bit 31 samples byte order pin
// RULE_04 - bit 30 samples role select pin
// RULE_05 - bit 29 samples area 0 type pin
// RULE_06 - reserved bits read zero, write zero
// RULE_07 - bit 25 turns input pull-ups off
// RULE_08 - bit 24 turns output pull-ups off
// RULE_09 - bit 21 area 1 byte control
// RULE_10 - bit 20 area 4 byte control
// RULE_11 - bit 19 accepts external requests, master only
// RULE_12 - bit 18 partial sharing, master only
// RULE_13 - bit 17 forces areas 1-6 multiplexed
// RULE_14 - burst codes select sram or burst length
// RULE_15 - writes to read-only bits ignored
`timescale 1ns/10ps
module bacr_top
  import bacr_pkg::*;
(
  // clock and resets
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_por,
  input wire logic i_ce,
  // wishbone
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  output logic o_wb_err,
  // mode pins
  input wire logic i_byte_order_pin,
  input wire logic i_role_select_pin,
  input wire logic i_area0_type_pin,
  // bus request
  input wire logic i_ext_bus_request,
  output logic o_ext_bus_grant_req,
  // configuration out
  output logic o_little_endian,
  output logic o_slave_mode,
  output logic o_input_pullup_on,
  output logic o_output_pullup_on,
  output logic o_partial_sharing,
  output bacr_area_t o_area0,
  output bacr_area_t o_area1,
  output bacr_area_t o_area4,
  output bacr_area_t o_area5,
  output bacr_area_t o_area6
);
  logic [31:0] ctrl_r;
  logic [31:0] ctrl_nxt;
  logic [31:0] rdat_r;
  logic wr;
  logic hit;
  logic por_d_r;
  logic req_r;
  bacr_wb_req_t req;

  assign req.cyc = i_wb_cyc;
  assign req.stb = i_wb_stb;
  assign req.we = i_wb_we;
  assign req.adr = i_wb_adr;
  assign req.sel = i_wb_sel;
  assign req.dat = i_wb_dat;

  bacr_wb_slave u_wb (
    .i_mclk(i_mclk),
    .i_rst(i_por),
    .i_ce(i_ce),
    .i_req(req),
    .o_ack(o_wb_ack),
    .o_err(o_wb_err),
    .o_wr(wr),
    .o_hit(hit)
  );

  // byte lanes, writable mask keeps flags and zeroes reserved bits
  always_comb begin
    ctrl_nxt = ctrl_r;
    for (int i = 0; i < 4; i++) begin
      if (i_wb_sel[i]) begin
        ctrl_nxt[i*8 +: 8] = i_wb_dat[i*8 +: 8];
      end
    end
    ctrl_nxt = (ctrl_nxt & BACR_WR_MASK) | (ctrl_r & BACR_RO_MASK); // RULE_15
  end

  // manual reset deliberately not used here
  always_ff @(posedge i_mclk) begin
    if (i_por) begin
      ctrl_r <= BACR_RESET_VAL; // RULE_01
    end else if (por_d_r && i_ce) begin
      // pins caught on the first enabled edge after power-on release
      ctrl_r[BACR_B_ENDIAN] <= i_byte_order_pin; // RULE_03
      ctrl_r[BACR_B_ROLE] <= i_role_select_pin; // RULE_04
      ctrl_r[BACR_B_A0MUX] <= i_area0_type_pin; // RULE_05
    end else if (i_ce && wr) begin
      ctrl_r <= ctrl_nxt; // RULE_06
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_por) begin
      por_d_r <= 1'b1;
    end else if (i_ce) begin
      // held while frozen so the pins are still caught
      por_d_r <= 1'b0;
    end
  end

  // read data registered; reserved bits are zero by the mask
  always_ff @(posedge i_mclk) begin
    if (i_por) begin
      rdat_r <= 32'h00000000;
    end else if (i_ce) begin
      rdat_r <= hit ? (ctrl_r & (BACR_WR_MASK | BACR_RO_MASK))
                    : 32'h00000000; // RULE_06
    end
  end
  assign o_wb_dat = rdat_r;

  // external requests only in master start
  always_ff @(posedge i_mclk) begin
    if (i_rst || i_por) begin
      req_r <= 1'b0;
    end else if (i_ce) begin
      req_r <= i_ext_bus_request && ctrl_r[BACR_B_REQEN]
               && !ctrl_r[BACR_B_ROLE]; // RULE_11
    end
  end
  assign o_ext_bus_grant_req = req_r;

  assign o_little_endian = ctrl_r[BACR_B_ENDIAN];
  assign o_slave_mode = ctrl_r[BACR_B_ROLE];
  assign o_input_pullup_on = !ctrl_r[BACR_B_IPU]; // RULE_07
  assign o_output_pullup_on = !ctrl_r[BACR_B_OPU]; // RULE_08
  assign o_partial_sharing = ctrl_r[BACR_B_SHARE]
                             && !ctrl_r[BACR_B_ROLE]; // RULE_12

  bacr_area_dec u_a0 (
    .i_burst(ctrl_r[BACR_B_A0BST +: 3]),
    .i_mux(ctrl_r[BACR_B_A0MUX]),
    .i_byte_ctrl(1'b0),
    .o_area(o_area0)
  );
  bacr_area_dec u_a1 (
    .i_burst(3'h0),
    .i_mux(ctrl_r[BACR_B_MUX]), // RULE_13
    .i_byte_ctrl(ctrl_r[BACR_B_A1BC]),
    .o_area(o_area1)
  );
  bacr_area_dec u_a4 (
    .i_burst(3'h0),
    .i_mux(ctrl_r[BACR_B_MUX]),
    .i_byte_ctrl(ctrl_r[BACR_B_A4BC]), // RULE_10
    .o_area(o_area4)
  );
  bacr_area_dec u_a5 (
    .i_burst(ctrl_r[BACR_B_A5BST +: 3]),
    .i_mux(ctrl_r[BACR_B_MUX]),
    .i_byte_ctrl(1'b0),
    .o_area(o_area5)
  );
  bacr_area_dec u_a6 (
    .i_burst(ctrl_r[BACR_B_A6BST +: 3]),
    .i_mux(ctrl_r[BACR_B_MUX]),
    .i_byte_ctrl(1'b0),
    .o_area(o_area6)
  );
endmodule

// ---- hdl/bacr_pkg.sv ----
// Purpose: constants and carriers for the bus area control register
// Assumes: one 32-bit register on a classic wishbone slave
// Notes: power-on reset is separate from manual reset
package bacr_pkg;
  localparam logic [7:0] BACR_OFS_CTRL = 8'h00;
  localparam logic [31:0] BACR_RESET_VAL = 32'h00000000;
  localparam int BACR_B_ENDIAN = 31;
  localparam int BACR_B_ROLE = 30;
  localparam int BACR_B_A0MUX = 29;
  localparam int BACR_B_IPU = 25;
  localparam int BACR_B_OPU = 24;
  localparam int BACR_B_A1BC = 21;
  localparam int BACR_B_A4BC = 20;
  localparam int BACR_B_REQEN = 19;
  localparam int BACR_B_SHARE = 18;
  localparam int BACR_B_MUX = 17;
  localparam int BACR_B_A0BST = 11;
  localparam int BACR_B_A5BST = 8;
  localparam int BACR_B_A6BST = 5;
  // software-writable bits: 25,24,21..17,15..2,0
  localparam logic [31:0] BACR_WR_MASK = 32'h033efffd;
  localparam logic [31:0] BACR_RO_MASK = 32'he0000000;

  typedef enum logic [2:0] {
    BACR_IF_SRAM = 3'h0,
    BACR_IF_B4 = 3'h1,
    BACR_IF_B8 = 3'h2,
    BACR_IF_B16 = 3'h3,
    BACR_IF_B32 = 3'h4
  } bacr_burst_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } bacr_wb_req_t;

  typedef struct packed {
    logic sram;
    logic mux;
    logic burst;
    logic [5:0] blen;
    logic byte_ctrl;
  } bacr_area_t;
endpackage

// ---- hdl/bacr_area_dec.sv ----
// Purpose: decode one area's access type
// Assumes: burst code per area, reserved codes fall back to sram
// Notes: multiplexed selection overrides burst and byte control
`timescale 1ns/10ps
module bacr_area_dec
  import bacr_pkg::*;
(
  // config
  input wire logic [2:0] i_burst,
  input wire logic i_mux,
  input wire logic i_byte_ctrl,
  // result
  output bacr_area_t o_area
);
  always_comb begin
    o_area = '0;
    o_area.mux = i_mux;
    if (!i_mux) begin
      o_area.byte_ctrl = i_byte_ctrl; // RULE_09
      unique case (i_burst) // RULE_14
        BACR_IF_B4: o_area.blen = 6'h04;
        BACR_IF_B8: o_area.blen = 6'h08;
        BACR_IF_B16: o_area.blen = 6'h10;
        BACR_IF_B32: o_area.blen = 6'h20;
        default: o_area.blen = 6'h00;
      endcase
      o_area.burst = (o_area.blen != 6'h00);
      o_area.sram = !o_area.burst;
    end
  end
endmodule

// ---- hdl/bacr_wb_slave.sv ----
// Purpose: classic wishbone slave handshake, one wait-free cycle
// Assumes: master holds request until ack
// Notes: ack drops the cycle after it was given
`timescale 1ns/10ps
module bacr_wb_slave
  import bacr_pkg::*;
(
  // clock
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire logic i_ce,
  // bus
  input wire bacr_wb_req_t i_req,
  output logic o_ack,
  output logic o_err,
  // strobes
  output logic o_wr,
  output logic o_hit
);
  logic ack_r;
  logic err_r;
  logic live;
  assign live = i_req.cyc && i_req.stb && !ack_r && !err_r;
  assign o_hit = (i_req.adr == BACR_OFS_CTRL);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      err_r <= 1'b0;
    end else if (i_ce) begin
      ack_r <= live && o_hit;
      err_r <= live && !o_hit;
    end
  end
  assign o_ack = ack_r;
  assign o_err = err_r;
  // write lands on the edge that drops ack
  assign o_wr = ack_r && i_req.we && i_req.cyc && i_req.stb && o_hit;
endmodule

// ---- sim/bacr_top_sva.sv ----
// Purpose: port checks for the area control register
// Assumes: one clock, i_por clears the register
// Notes: reserved and pin flags judged on reads
`timescale 1ns/10ps
module bacr_top_sva
  import bacr_pkg::*;
(
  // watched ports
  input wire logic i_mclk, i_por, i_ce, i_wb_cyc, i_wb_stb, i_wb_we,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack, o_wb_err, i_byte_order_pin,
  input wire logic i_role_select_pin, o_little_endian, o_slave_mode,
  input wire logic o_input_pullup_on, o_output_pullup_on,
  input wire logic o_partial_sharing, i_ext_bus_request,
  input wire logic o_ext_bus_grant_req,
  input wire bacr_area_t o_area1
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_por);
  sequence s_req;
    i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack && !o_wb_err;
  endsequence
  sequence s_rd;
    o_wb_ack && !i_wb_we;
  endsequence
  chk_bus_answer: assert property (s_req |=> o_wb_ack || o_wb_err)
    else $error("request not answered");
  chk_ack_pulse: assert property (o_wb_ack && i_ce |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  chk_rsvd_zero: assert property
    (s_rd |-> (o_wb_dat & 32'h1cc10002) == 32'h0) else $error("reserved set");
  chk_pullup_map: assert property (s_rd |->
    o_wb_dat[25:24] == ~{o_input_pullup_on, o_output_pullup_on})
    else $error("pull-up outputs disagree");
  chk_flag_map: assert property (s_rd |->
    o_wb_dat[31:30] == {o_little_endian, o_slave_mode})
    else $error("flag outputs disagree");
  chk_share_master: assert property (s_rd |->
    o_partial_sharing == (o_wb_dat[18] && !o_wb_dat[30]))
    else $error("sharing in slave start");
  chk_grant_cause: assert property (o_ext_bus_grant_req && $past(i_ce) |->
    $past(i_ext_bus_request) && !o_slave_mode) else $error("bad grant");
  chk_pin_sample: assert property ($fell(i_por) |=>
    o_little_endian == $past(i_byte_order_pin) &&
    o_slave_mode == $past(i_role_select_pin)) else $error("pin missed");
  chk_flag_hold: assert property (!$past(i_por) && !$past(i_por, 2) |->
    $stable(o_little_endian) && $stable(o_slave_mode))
    else $error("pin flag changed");
  chk_mux_wins: assert property (o_area1.mux |-> !o_area1.byte_ctrl)
    else $error("byte control beat mux");
endmodule

bind bacr_top bacr_top_sva i_sva(.*);

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the area control register
// Assumes: register at offset zero, full byte lanes except two lane 1 writes
// Notes: config outputs read at negedge so they have settled; read data and err taken at the posedge that sees ack or err
`timescale 1ns/10ps
module tb_top;
  import bacr_pkg::*;
  logic i_mclk, i_rst, i_por, i_ce, i_wb_cyc, i_wb_stb, i_wb_we, e;
  logic [7:0] i_wb_adr;
  logic [3:0] i_wb_sel;
  logic [31:0] i_wb_dat, o_wb_dat, q;
  logic o_wb_ack, o_wb_err, i_byte_order_pin, i_role_select_pin;
  logic i_area0_type_pin, i_ext_bus_request, o_ext_bus_grant_req;
  logic o_little_endian, o_slave_mode, o_input_pullup_on;
  logic o_output_pullup_on, o_partial_sharing;
  bacr_area_t o_area0, o_area1, o_area4, o_area5, o_area6;
  int bad_count, num_checks, cyc_n;
  logic [1:0] bexp;
  // software keeps reserved bits at zero
  localparam logic [31:0] ALL_LEGAL = 32'he33efffd;
  bacr_top i_bacr_top(.*);
  initial begin
    i_mclk = 0;
    forever #5 i_mclk = ~i_mclk;
  end
  task chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  task close_out;
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 3000) begin
      bad_count++;
      close_out();
    end
  end
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    {i_wb_cyc, i_wb_stb, i_wb_we} <= {2'h3, w};
    i_wb_adr <= a;
    i_wb_dat <= d;
    do @(posedge i_mclk); while (o_wb_ack !== 1'b1 && o_wb_err !== 1'b1);
    q = o_wb_dat;
    e = o_wb_err;
    {i_wb_cyc, i_wb_stb} <= 2'h0;
    @(negedge i_mclk);
  endtask
  task por(input logic [2:0] p);
    @(posedge i_mclk);
    {i_byte_order_pin, i_role_select_pin, i_area0_type_pin} <= p;
    {i_por, i_rst} <= 2'h3;
    repeat (20) @(posedge i_mclk);
    {i_por, i_rst} <= 2'h0;
    repeat (2) @(negedge i_mclk);
  endtask
  initial begin
    {i_ce, i_wb_sel, i_wb_cyc, i_wb_stb, i_wb_we} = 8'hf8;
    {i_wb_adr, i_wb_dat, i_ext_bus_request} = '0;
    {i_por, i_rst} = 2'h3;
    por(3'h5);
    wb(0, 8'h00, 32'h0);
    chk(q, 32'ha0000000);
    chk({o_area0.mux, o_input_pullup_on}, 2'h3);
    $display("reset test done");
    wb(1, 8'h00, ALL_LEGAL);
    chk({o_input_pullup_on, o_output_pullup_on}, 2'h0);
    chk({o_partial_sharing, o_area1.mux}, 2'h3);
    wb(0, 8'h00, 32'h0);
    chk(q, 32'ha0000000 | BACR_WR_MASK);
    @(posedge i_mclk);
    i_ext_bus_request <= 1'b1;
    repeat (2) @(negedge i_mclk);
    chk(o_ext_bus_grant_req, 1'b1);
    // clock enable low must freeze the grant
    @(posedge i_mclk);
    {i_ce, i_ext_bus_request} <= 2'h0;
    repeat (2) @(negedge i_mclk);
    chk(o_ext_bus_grant_req, 1'b1);
    @(posedge i_mclk);
    i_ce <= 1'b1;
    repeat (2) @(negedge i_mclk);
    chk(o_ext_bus_grant_req, 1'b0);
    @(posedge i_mclk);
    i_ext_bus_request <= 1'b1;
    $display("write test done");
    for (int c = 0; c < 8; c++) begin
      wb(1, 8'h00, 32'h00300000 | 32'(c << 11) | 32'(c << 8) | 32'(c << 5));
      bexp = (c inside {[1:4]}) ? 2'h1 : 2'h2;
      chk({o_area1.byte_ctrl, o_area4.byte_ctrl}, 2'h3);
      chk({o_area5.sram, o_area5.burst}, bexp);
      chk({o_area6.sram, o_area6.burst}, bexp);
      if (c inside {[1:4]}) chk(o_area5.blen, 6'h2 << c);
      chk(o_area0.burst, 1'b0);
    end
    chk(o_ext_bus_grant_req, 1'b0);
    $display("area test done");
    @(posedge i_mclk);
    i_rst <= 1'b1;
    i_wb_sel <= 4'h2;
    @(posedge i_mclk);
    i_rst <= 1'b0;
    wb(1, 8'h04, 32'hffffffff);
    chk(e, 1'b1);
    // only lane 1 enabled, so just bits 15..8 clear
    wb(1, 8'h00, 32'h0);
    @(posedge i_mclk);
    i_wb_sel <= 4'hf;
    wb(0, 8'h00, 32'h0);
    chk(q, 32'ha03000e0);
    $display("manual reset test done");
    por(3'h2);
    wb(1, 8'h00, ALL_LEGAL);
    chk({o_slave_mode, o_partial_sharing, o_area0.mux}, 3'h4);
    repeat (2) @(negedge i_mclk);
    chk(o_ext_bus_grant_req, 1'b0);
    wb(0, 8'h00, 32'h0);
    chk(q, 32'h40000000 | BACR_WR_MASK);
    $display("slave start test done");
    close_out();
  end
endmodule
